// ===== hw/ots_defines.svh
// Offsets, field positions and reset values of the stop logic.
`ifndef OTS_DEFINES_SVH
`define OTS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses on APB)
// ----------------------------------------------------------------------------
`define OTS_ADDR_SWITCH   12'h000
`define OTS_ADDR_TORQUE   12'h004
`define OTS_ADDR_CONTROL  12'h008
`define OTS_ADDR_STATUS   12'h00C

// ----------------------------------------------------------------------------
// Switch word fields
// ----------------------------------------------------------------------------
`define OTS_SW_FWD_IGN    2
`define OTS_SW_REV_IGN    3
`define OTS_SW_COAST      6
`define OTS_SW_DB_KEEP    7
`define OTS_SW_OT_DECEL   8
`define OTS_SW_OT_CLAMP   9
`define OTS_SW_RESET      16'h0080

// ----------------------------------------------------------------------------
// Torque setting and control fields
// ----------------------------------------------------------------------------
`define OTS_TRQ_MAX       16'h012C
`define OTS_CTL_ENABLE    0
`define OTS_CTL_TORQUE    1
`define OTS_CTL_ALARM     2
`define OTS_CTL_POWER     3
`define OTS_CTL_RESET     16'h0008

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define OTS_ST_FWD_OK     0
`define OTS_ST_REV_OK     1
`define OTS_ST_SERVO_ON   2
`define OTS_ST_DB         3
`define OTS_ST_DECEL      4
`define OTS_ST_CLAMP      5
`define OTS_ST_COAST      6
`define OTS_ST_STATE_LSB  8

`endif

// ===== hw/ots_pkg.sv
// Types shared by the overtravel and stop-mode logic.
package ots_pkg;

  // One-hot stop sequence states.
  typedef enum logic [5:0] {
    OTS_RUN   = 6'h01,
    OTS_DECEL = 6'h02,
    OTS_CLAMP = 6'h04,
    OTS_DB    = 6'h08,
    OTS_COAST = 6'h10,
    OTS_OFF   = 6'h20
  } ots_state_t;

endpackage

// ===== hw/ots_cfg_if.sv
// Interface carrying configuration from the register block to the core.
`timescale 1ns/1ns
`default_nettype none
interface ots_cfg_if;
  logic [15:0] switch_word;
  logic [15:0] stop_torque;
  logic        drive_enable;
  logic        torque_mode;
  logic        alarm;
  logic        power_ok;
  logic [7:0]  status;

  modport regs (output switch_word, stop_torque, drive_enable, torque_mode,
                output alarm, power_ok, input status);
  modport core (input switch_word, stop_torque, drive_enable, torque_mode,
                input alarm, power_ok, output status);
endinterface
`default_nettype wire

// ===== hw/ots_sync2.sv
// Two-stage synchroniser for the two travel-limit inputs.
`timescale 1ns/1ns
`default_nettype none
module ots_sync2
  import ots_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Data
  input  wire logic [1:0] async_i,
  output logic      [1:0] sync_o
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } ots_sync_t;

  ots_sync_t st_q, st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
  end

  // Reset to 1: an open switch reads as prohibited until sampled.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '{s1: 2'h3, s2: 2'h3};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.s2;
endmodule
`default_nettype wire

// ===== hw/ots_regs.sv
// APB register block holding the switch word, stop torque and controls.
`timescale 1ns/1ns
`default_nettype none
`include "ots_defines.svh"
module ots_regs
  import ots_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Configuration to the core
  ots_cfg_if.regs          cfg
);
  typedef struct packed {
    logic [15:0] sw;
    logic [15:0] trq;
    logic [15:0] ctl;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } ots_regs_t;

  ots_regs_t st_q, st_d;

  function automatic logic known(input logic [11:0] a);
    known = (a == `OTS_ADDR_SWITCH) || (a == `OTS_ADDR_TORQUE) ||
            (a == `OTS_ADDR_CONTROL) || (a == `OTS_ADDR_STATUS);
  endfunction

  // One wait state: the answer comes in the second access cycle.
  always_comb begin
    st_d       = st_q;
    st_d.ready = 1'b0;
    st_d.err   = 1'b0;
    if (psel_i && penable_i && !st_q.ready) begin
      st_d.ready = 1'b1;
      st_d.err   = !known(paddr_i);
      st_d.rdata = 32'h0;
      if (pwrite_i) begin
        case (paddr_i)
          `OTS_ADDR_SWITCH:  st_d.sw  = pwdata_i[15:0];
          `OTS_ADDR_TORQUE:  st_d.trq = pwdata_i[15:0];
          `OTS_ADDR_CONTROL: st_d.ctl = pwdata_i[15:0];
          default:           st_d.sw  = st_q.sw;
        endcase
      end else begin
        case (paddr_i)
          `OTS_ADDR_SWITCH:  st_d.rdata = {16'h0, st_q.sw};
          `OTS_ADDR_TORQUE:  st_d.rdata = {16'h0, st_q.trq};
          `OTS_ADDR_CONTROL: st_d.rdata = {16'h0, st_q.ctl};
          `OTS_ADDR_STATUS:  st_d.rdata = {24'h0, cfg.status};
          default:           st_d.rdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '{sw: `OTS_SW_RESET, trq: `OTS_TRQ_MAX, ctl: `OTS_CTL_RESET,
                rdata: 32'h0, ready: 1'b0, err: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata_o         = st_q.rdata;
  assign pready_o         = st_q.ready;
  assign pslverr_o        = st_q.err;
  assign cfg.switch_word  = st_q.sw;
  assign cfg.stop_torque  = st_q.trq;
  assign cfg.drive_enable = st_q.ctl[`OTS_CTL_ENABLE];
  assign cfg.torque_mode  = st_q.ctl[`OTS_CTL_TORQUE];
  assign cfg.alarm        = st_q.ctl[`OTS_CTL_ALARM];
  assign cfg.power_ok     = st_q.ctl[`OTS_CTL_POWER];

  chk_reset_defaults: assert property (@(posedge clk_sys_i)
    $rose(rst_n_i) |-> st_q.sw[`OTS_SW_DB_KEEP] && !st_q.sw[`OTS_SW_OT_DECEL])
    else $error("switch word not at factory default after reset");
endmodule
`default_nettype wire

// ===== hw/ots_top.sv
// Overtravel limit and stop-mode decision logic of a servo drive.
//
// Behaviour
// - Forward motion allowed while forward limit input is low, blocked when high.
// - Reverse motion allowed while reverse limit input is low, blocked when high.
// - Switch bit 2 set ignores the forward limit input entirely.
// - Switch bit 3 set ignores the reverse limit input entirely.
// - At overtravel bit 8 clear stops like servo-off, set decelerates.
// - After overtravel deceleration bit 9 clear turns servo off, set clamps.
// - Torque control mode always stops overtravel like servo-off.
// - Emergency torque is percent of rated, defaults to maximum.
// - Enable low, alarm or power loss puts the drive in servo-off.
// - Servo-off stop uses dynamic brake when bit 6 clear, coasts otherwise.
// - After brake stop bit 7 clear releases brake, set keeps it.
// - Bits 6, 8, 9 reset to zero, bit 7 resets to one.
`timescale 1ns/1ns
`default_nettype none
`include "ots_defines.svh"
module ots_top
  import ots_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Limit switches, high or open means limit reached
  input  wire logic        fwd_travel_limit_in_i,
  input  wire logic        rev_travel_limit_in_i,
  // Motion feedback
  input  wire logic        motor_at_rest_i,
  // Drive commands
  output logic             fwd_allowed_o,
  output logic             rev_allowed_o,
  output logic             servo_on_o,
  output logic             dyn_brake_o,
  output logic             decel_active_o,
  output logic [15:0]      emergency_torque_setting_o,
  output logic             zero_clamp_o,
  output logic             coast_o
);
  ots_cfg_if cfg ();
  logic [1:0] lim_s;

  typedef struct packed {
    ots_state_t  state;
    logic        fwd_ok;
    logic        rev_ok;
    logic        servo_on;
    logic        db;
    logic        decel;
    logic [15:0] trq;
    logic        clamp;
    logic        coast;
  } ots_core_t;

  ots_core_t st_q, st_d;

  // --------------------------------------------------------------------------
  // Registers and input synchronisation
  // --------------------------------------------------------------------------
  ots_regs u_regs (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .cfg       (cfg.regs)
  );

  ots_sync2 u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({rev_travel_limit_in_i, fwd_travel_limit_in_i}),
    .sync_o    (lim_s)
  );

  // --------------------------------------------------------------------------
  // Decision logic
  // --------------------------------------------------------------------------
  logic [15:0] sw;
  logic        fwd_ok_c;
  logic        rev_ok_c;
  logic        servo_off_req;
  logic        overtravel;

  assign sw = cfg.switch_word;
  // A set ignore bit behaves as if the input were tied low.
  assign fwd_ok_c = !lim_s[0] || sw[`OTS_SW_FWD_IGN];
  assign rev_ok_c = !lim_s[1] || sw[`OTS_SW_REV_IGN];
  assign servo_off_req = !cfg.drive_enable || cfg.alarm ||
                         !cfg.power_ok;
  assign overtravel = !fwd_ok_c || !rev_ok_c;

  // Servo-off stop entry point, shared by overtravel and servo-off events.
  function automatic ots_state_t off_stop(input logic [15:0] w);
    off_stop = w[`OTS_SW_COAST] ? OTS_COAST : OTS_DB;
  endfunction

  always_comb begin
    st_d        = st_q;
    st_d.fwd_ok = fwd_ok_c;
    st_d.rev_ok = rev_ok_c;
    st_d.trq    = cfg.stop_torque;
    case (st_q.state)
      OTS_RUN: begin
        if (servo_off_req) begin
          st_d.state = off_stop(sw);
        end else if (overtravel) begin
          if (sw[`OTS_SW_OT_DECEL] && !cfg.torque_mode) begin
            st_d.state = OTS_DECEL;
          end else begin
            st_d.state = off_stop(sw);
          end
        end
      end
      OTS_DECEL: begin
        if (servo_off_req) begin
          st_d.state = off_stop(sw);
        end else if (motor_at_rest_i) begin
          st_d.state = sw[`OTS_SW_OT_CLAMP] ? OTS_CLAMP
                                            : off_stop(sw);
        end
      end
      OTS_CLAMP: begin
        if (servo_off_req) begin
          st_d.state = off_stop(sw);
        end else if (!overtravel) begin
          st_d.state = OTS_RUN;
        end
      end
      OTS_DB: begin
        if (motor_at_rest_i) begin
          st_d.state = OTS_OFF;
        end
      end
      OTS_COAST: begin
        if (motor_at_rest_i) begin
          st_d.state = OTS_OFF;
        end
      end
      OTS_OFF: begin
        // Resume only once every stop cause has cleared.
        if (!servo_off_req && !overtravel) begin
          st_d.state = OTS_RUN;
        end
      end
      default: st_d.state = OTS_OFF;
    endcase
    st_d.servo_on = (st_d.state == OTS_RUN) || (st_d.state == OTS_DECEL) ||
                    (st_d.state == OTS_CLAMP);
    st_d.decel    = (st_d.state == OTS_DECEL);
    st_d.clamp    = (st_d.state == OTS_CLAMP);
    st_d.coast    = (st_d.state == OTS_COAST);
    // The brake stays on at rest only when the keep bit asks for it.
    st_d.db       = (st_d.state == OTS_DB) ||
                    ((st_d.state == OTS_OFF) && sw[`OTS_SW_DB_KEEP] &&
                     !sw[`OTS_SW_COAST]);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '{state: OTS_OFF, fwd_ok: 1'b0, rev_ok: 1'b0, servo_on: 1'b0,
                db: 1'b1, decel: 1'b0, trq: `OTS_TRQ_MAX, clamp: 1'b0,
                coast: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg.status = {2'h0, st_q.coast, st_q.clamp, st_q.decel, st_q.db,
                       st_q.servo_on, st_q.fwd_ok} & 8'hFF |
                      {6'h0, st_q.rev_ok, 1'b0};

  assign fwd_allowed_o              = st_q.fwd_ok;
  assign rev_allowed_o              = st_q.rev_ok;
  assign servo_on_o                 = st_q.servo_on;
  assign dyn_brake_o                = st_q.db;
  assign decel_active_o             = st_q.decel;
  assign emergency_torque_setting_o = st_q.trq;
  assign zero_clamp_o               = st_q.clamp;
  assign coast_o                    = st_q.coast;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_fwd_hit;
    lim_s[0] && !sw[`OTS_SW_FWD_IGN];
  endsequence

  chk_fwd_block: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_fwd_hit |=> !fwd_allowed_o)
    else $error("forward allowed at forward limit");
  chk_rev_block: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    lim_s[1] && !sw[`OTS_SW_REV_IGN] |=> !rev_allowed_o)
    else $error("reverse allowed at reverse limit");
  chk_fwd_ignore: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sw[`OTS_SW_FWD_IGN] |=> fwd_allowed_o)
    else $error("forward blocked while input ignored");
  chk_rev_ignore: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sw[`OTS_SW_REV_IGN] |=> rev_allowed_o)
    else $error("reverse blocked while input ignored");
  chk_ot_decel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    st_q.state == OTS_RUN && !servo_off_req && overtravel &&
    sw[`OTS_SW_OT_DECEL] && !cfg.torque_mode |=> decel_active_o)
    else $error("overtravel did not start deceleration");
  chk_clamp_after: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    st_q.state == OTS_DECEL && !servo_off_req && motor_at_rest_i &&
    sw[`OTS_SW_OT_CLAMP] |=> zero_clamp_o && servo_on_o)
    else $error("no zero clamp after deceleration stop");
  chk_torque_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    cfg.torque_mode && st_q.state == OTS_RUN |=> !decel_active_o)
    else $error("deceleration stop in torque mode");
  chk_servo_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    servo_off_req |=> !servo_on_o)
    else $error("servo still on after stop request");
  chk_coast_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    st_q.state == OTS_RUN && servo_off_req |=>
    (coast_o == $past(sw[`OTS_SW_COAST])) && (dyn_brake_o != coast_o))
    else $error("wrong servo-off stop method");
  chk_db_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    st_q.state == OTS_OFF && !sw[`OTS_SW_DB_KEEP] ##1
    st_q.state == OTS_OFF |-> !dyn_brake_o)
    else $error("dynamic brake held though release selected");
  chk_torque_out: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ##1 emergency_torque_setting_o == $past(cfg.stop_torque))
    else $error("emergency torque output stale");
endmodule
`default_nettype wire

// ===== verification/ots_far_model.sv
// Model of the travel-limit switches and of the motor running down.
`timescale 1ns/1ns
`default_nettype none
module ots_far_model #(
  parameter int REST_CYC = 16
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Switch actuation and drive state
  input  wire logic fwd_hit_i,
  input  wire logic rev_hit_i,
  input  wire logic servo_on_i,
  input  wire logic decel_i,
  input  wire logic clamp_i,
  // Toward the drive
  output logic      fwd_pin_o,
  output logic      rev_pin_o,
  output logic      at_rest_o
);
  // ------------------------
  // Switches and motor
  // ------------------------
  int cnt_q;
  // An actuated switch opens its contact and the pulled-up pin reads high.
  assign fwd_pin_o = fwd_hit_i;
  assign rev_pin_o = rev_hit_i;
  // Rest comes only after a run-down, so the stop states are seen first.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q     <= 0;
      at_rest_o <= 1'b1;
    end else if (servo_on_i && !decel_i && !clamp_i) begin
      cnt_q     <= 0;
      at_rest_o <= 1'b0;
    end else if (cnt_q >= REST_CYC) begin
      at_rest_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/test_overtravel_stop_mode_logic.sv
// Self-checking bench of the overtravel and stop-mode logic.
`timescale 1ns/1ns
`default_nettype none
`include "ots_defines.svh"
module test_overtravel_stop_mode_logic
  import ots_pkg::*;
;
  // ------------------------
  // Signals and instances
  // ------------------------
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fwd_hit;
  logic        rev_hit;
  logic        fwd_pin;
  logic        rev_pin;
  logic        at_rest;
  logic        fwd_ok;
  logic        rev_ok;
  logic        son;
  logic        db;
  logic        dec;
  logic [15:0] etrq;
  logic        clamp;
  logic        coast;
  int          err_total;
  int          check_count;
  logic [31:0] rd;
  logic        er;

  always #50 clk = ~clk;

  ots_top i_dut (
    .clk_sys_i                 (clk),
    .rst_n_i                   (rst_n),
    .psel_i                    (psel),
    .penable_i                 (penable),
    .pwrite_i                  (pwrite),
    .paddr_i                   (paddr),
    .pwdata_i                  (pwdata),
    .prdata_o                  (prdata),
    .pready_o                  (pready),
    .pslverr_o                 (pslverr),
    .fwd_travel_limit_in_i     (fwd_pin),
    .rev_travel_limit_in_i     (rev_pin),
    .motor_at_rest_i           (at_rest),
    .fwd_allowed_o             (fwd_ok),
    .rev_allowed_o             (rev_ok),
    .servo_on_o                (son),
    .dyn_brake_o               (db),
    .decel_active_o            (dec),
    .emergency_torque_setting_o(etrq),
    .zero_clamp_o              (clamp),
    .coast_o                   (coast)
  );

  ots_far_model i_far (
    .clk_sys_i (clk),
    .rst_n_i   (rst_n),
    .fwd_hit_i (fwd_hit),
    .rev_hit_i (rev_hit),
    .servo_on_i(son),
    .decel_i   (dec),
    .clamp_i   (clamp),
    .fwd_pin_o (fwd_pin),
    .rev_pin_o (rev_pin),
    .at_rest_o (at_rest)
  );

  // ------------------------
  // Tasks and expectations
  // ------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Read data and the error flag land in rd and er.
  // The answer is taken at the rising edge at which pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    while (son !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(son, 1'b1);
  endtask

  function automatic logic [4:0] outs();
    return {son, coast, clamp, dec, db};
  endfunction

  // Upper five bits are a mask of the outputs that the case fixes.
  function automatic logic [9:0] expect_v(input logic [15:0] sw,
    input logic [15:0] ctl, input int lim, input bit after);
    logic dp;
    dp = (lim != 0) && sw[8] && !ctl[1];
    if (!after)
      return dp ? {5'b01111, 5'b00010}
                : {5'b11111, 1'b0, sw[6], 2'b00, !sw[6]};
    return (dp && sw[9]) ? {5'b01111, 5'b00100}
                         : {5'b10111, 4'b0000, !sw[6] && sw[7]};
  endfunction

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------
  // Sequence
  // ------------------------
  logic [15:0] c_sw [9] = '{16'h0080, 16'h0000, 16'h0040, 16'h0100,
    16'h0300, 16'h0180, 16'h0080, 16'h00C0, 16'h0000};
  logic [15:0] c_ctl [9] = '{16'h0009, 16'h0009, 16'h0009, 16'h0009,
    16'h0009, 16'h000B, 16'h0008, 16'h000D, 16'h0001};
  int          c_lim [9] = '{1, 2, 1, 1, 2, 1, 0, 0, 0};

  initial begin
    #(100 * 20000);
    err_total++;
    finish_test();
  end

  initial begin
    logic [31:0] t;
    logic [15:0] ctl;
    logic [9:0]  e;
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fwd_hit = 1'b0;
    rev_hit = 1'b0;
    err_total = 0;
    check_count = 0;
    void'($urandom(32'h1CA1D172));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(outs(), 5'b00001);
    check(etrq, 16'h012C);
    apb(1'b0, `OTS_ADDR_SWITCH, 32'h0);
    check(rd, 32'h0000_0080);
    apb(1'b0, `OTS_ADDR_TORQUE, 32'h0);
    check(rd, 32'h0000_012C);
    apb(1'b1, 12'h010, 32'h0000_FFFF);
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, er}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    t = $urandom_range(0, 300);
    apb(1'b1, `OTS_ADDR_TORQUE, t);
    apb(1'b0, `OTS_ADDR_TORQUE, 32'h0);
    check(rd, t);
    check(etrq, t[15:0]);
    for (int i = 0; i < 9; i++) begin
      ctl = (c_lim[i] != 0) ? c_ctl[i] : 16'h0009;
      apb(1'b1, `OTS_ADDR_SWITCH, {16'h0, c_sw[i]});
      apb(1'b1, `OTS_ADDR_CONTROL, {16'h0, ctl});
      wait_run();
      check({fwd_ok, rev_ok}, 2'b11);
      repeat ($urandom_range(1, 5)) @(posedge clk);
      if (c_lim[i] == 0) begin
        apb(1'b1, `OTS_ADDR_CONTROL, {16'h0, c_ctl[i]});
      end else begin
        @(posedge clk);
        fwd_hit <= (c_lim[i] == 1);
        rev_hit <= (c_lim[i] == 2);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({fwd_ok, rev_ok}, 2'b11);
        @(negedge clk);
        check({fwd_ok, rev_ok}, (c_lim[i] == 1) ? 2'b01 : 2'b10);
      end
      repeat (6) @(posedge clk);
      @(negedge clk);
      e = expect_v(c_sw[i], ctl, c_lim[i], 1'b0);
      check(outs() & e[9:5], e[4:0]);
      repeat (40) @(posedge clk);
      @(negedge clk);
      e = expect_v(c_sw[i], ctl, c_lim[i], 1'b1);
      check(outs() & e[9:5], e[4:0]);
      @(posedge clk);
      fwd_hit <= 1'b0;
      rev_hit <= 1'b0;
    end
    apb(1'b1, `OTS_ADDR_SWITCH, 32'h0000_008C);
    apb(1'b1, `OTS_ADDR_CONTROL, 32'h0000_0009);
    wait_run();
    @(posedge clk);
    fwd_hit <= 1'b1;
    rev_hit <= 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check({fwd_ok, rev_ok, son, dec, db}, 5'b11100);
    finish_test();
  end
endmodule
`default_nettype wire
